// [rtl/ardr_pkg.sv]
// Constants shared by both ends of the asynchronous receive clock and data recovery link
// Contract
// - Oversample 16x normal, 8x double speed
// - Mode field 0x00 normal, 0x01 double
// - Falling edge from idle; first low sample one
// - Validate start on samples 8-10 or 4-6
// - Two or more lows accept start bit
// - Fewer lows reject start, wait again
// - Majority vote three centre samples per bit
// - Check only first stop bit
// - Low voted stop bit sets framing error
// - Normal mode: next start right after vote
// - Double mode: next start after vote samples
// - Payload of five to ten bits
// - Normal mode transmitter error 3.0 to 1.5 percent
// - Double mode transmitter error 2.5 to 1.0 percent
// - Each side takes half the mismatch
package ardr_pkg;

    // ==========================================================
    // Receive sampling mode encodings
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_DOUBLE = 2'h1;

    // ==========================================================
    // Oversampling geometry, in samples
    localparam logic [4:0] SAMPLES_NORMAL = 5'h10;
    localparam logic [4:0] SAMPLES_DOUBLE = 5'h08;
    localparam logic [4:0] FIRST_VOTE_NORMAL = 5'h08;
    localparam logic [4:0] FIRST_VOTE_DOUBLE = 5'h04;
    localparam logic [4:0] VOTE_SPAN = 5'h02;

    // ==========================================================
    // Frame payload limits, data width and result buffer depth
    localparam logic [3:0] PAYLOAD_MIN = 4'h5;
    localparam logic [3:0] PAYLOAD_MAX = 4'hA;
    localparam int DATA_WIDTH = 10;
    localparam int FIFO_DEPTH = 16;

    // ==========================================================
    // Transmitter timing
    localparam int CLK_HZ = 10_000_000;
    localparam int BAUD_HZ = 9600;
    localparam int TX_CLKS_PER_BIT = CLK_HZ / BAUD_HZ;
    localparam int TX_STOP_BITS = 1;

    // ==========================================================
    // Line reset levels
    localparam logic LINE_IDLE = 1'b1;

endpackage : ardr_pkg

// [rtl/ardr_link_if.sv]
// Serial line between the remote transmitter and the recovering receiver
`timescale 1ns/1ns
`default_nettype none
interface ardr_link_if;
    logic serial_line;

    modport rx_end (input serial_line);
    modport tx_end (output serial_line);
endinterface : ardr_link_if
`default_nettype wire

// [rtl/ardr_rx_end.sv]
// Receiver end: start detection, majority-vote data recovery and result FIFO
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Result buffer
module ardr_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = ardr_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] count_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = count_q != (AW+1)'(DEPTH);
    assign out_valid = count_q != '0;
    assign out_data = mem_q[rd_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : ardr_fifo

// ==========================================================
// Clock and data recovery
module ardr_rx_end #(
    parameter int FIFO_DEPTH = ardr_pkg::FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic sample_tick,
    input wire logic [1:0] rx_sampling_mode,
    input wire logic [3:0] frame_bits,
    ardr_link_if.rx_end link,
    output logic out_valid,
    input wire logic out_ready,
    output logic [ardr_pkg::DATA_WIDTH-1:0] out_data,
    output logic out_frame_err
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_START = 4'b0010,
        ST_DATA = 4'b0100,
        ST_STOP = 4'b1000
    } ardr_state_type;

    ardr_state_type state_q;
    logic [4:0] cnt_q;
    logic [1:0] lows_q;
    logic prev_q;
    logic [3:0] idx_q;
    logic [ardr_pkg::DATA_WIDTH-1:0] shreg_q;
    logic res_valid_q;
    logic [ardr_pkg::DATA_WIDTH-1:0] res_data_q;
    logic res_ferr_q;
    logic fifo_in_ready;

    wire line = link.serial_line;
    wire is_double = rx_sampling_mode == ardr_pkg::MODE_DOUBLE;
    wire [4:0] spb = is_double ? ardr_pkg::SAMPLES_DOUBLE : ardr_pkg::SAMPLES_NORMAL;
    wire [4:0] first_vote = is_double ? ardr_pkg::FIRST_VOTE_DOUBLE : ardr_pkg::FIRST_VOTE_NORMAL;
    wire [4:0] last_vote_n = first_vote + ardr_pkg::VOTE_SPAN;
    wire in_vote = (cnt_q >= first_vote) && (cnt_q <= last_vote_n);
    wire last_vote = cnt_q == last_vote_n;
    wire bit_end = cnt_q == spb;
    wire [1:0] lows_next = lows_q + {1'b0, ~line};
    wire vote_low = lows_next[1];
    // A result leaving the holding register on this edge does not block the next start
    wire edge_seen = prev_q && !line && !(res_valid_q && !fifo_in_ready);
    wire [3:0] payload = (frame_bits < ardr_pkg::PAYLOAD_MIN) ? ardr_pkg::PAYLOAD_MIN :
                         (frame_bits > ardr_pkg::PAYLOAD_MAX) ? ardr_pkg::PAYLOAD_MAX : frame_bits;
    wire run = state_q != ST_IDLE;

    // Line history for edge detection, advanced only on sample ticks
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            prev_q <= ardr_pkg::LINE_IDLE;
        end else if (sample_tick) begin
            prev_q <= line;
        end
    end

    // Sample position within the bit and low-vote tally
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cnt_q <= 5'h01;
            lows_q <= 2'h0;
        end else if (sample_tick) begin
            if (!run) begin
                // The detecting tick is sample one, so the following tick is sample two
                cnt_q <= edge_seen ? 5'h02 : 5'h01;
                lows_q <= 2'h0;
            end else if (bit_end) begin
                cnt_q <= 5'h01;
                lows_q <= 2'h0;
            end else begin
                cnt_q <= cnt_q + 5'h01;
                if (in_vote) begin
                    lows_q <= lows_next;
                end
            end
        end
    end

    // Frame sequencing
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
            idx_q <= 4'h0;
            shreg_q <= '0;
        end else if (sample_tick) begin
            case (state_q)
                ST_IDLE: begin
                    if (edge_seen) begin
                        state_q <= ST_START;
                    end
                end
                ST_START: begin
                    if (last_vote && !vote_low) begin
                        state_q <= ST_IDLE;
                    end else if (last_vote) begin
                        idx_q <= 4'h0;
                        shreg_q <= '0;
                    end else if (bit_end) begin
                        state_q <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (last_vote) begin
                        shreg_q[idx_q] <= ~vote_low;
                        idx_q <= idx_q + 4'h1;
                    end else if (bit_end && idx_q == payload) begin
                        state_q <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (last_vote) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Completed frame waits here until the buffer accepts it
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            res_valid_q <= 1'b0;
            res_data_q <= '0;
            res_ferr_q <= 1'b0;
        end else if (sample_tick && state_q == ST_STOP && last_vote) begin
            res_valid_q <= 1'b1;
            res_data_q <= shreg_q;
            res_ferr_q <= vote_low;
        end else if (fifo_in_ready) begin
            res_valid_q <= 1'b0;
        end
    end

    ardr_fifo #(
        .WIDTH(ardr_pkg::DATA_WIDTH + 1),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(ref_clk),
        .reset(reset),
        .in_valid(res_valid_q),
        .in_ready(fifo_in_ready),
        .in_data({res_ferr_q, res_data_q}),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data({out_frame_err, out_data})
    );
endmodule : ardr_rx_end
`default_nettype wire

// [rtl/ardr_tx_end.sv]
// Remote transmitter end: frames words onto the serial line at its own baud
`timescale 1ns/1ns
`default_nettype none
module ardr_tx_end #(
    parameter int CLKS_PER_BIT = ardr_pkg::TX_CLKS_PER_BIT,
    parameter int STOP_BITS = ardr_pkg::TX_STOP_BITS
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [ardr_pkg::DATA_WIDTH-1:0] in_data,
    input wire logic [3:0] frame_bits,
    ardr_link_if.tx_end link
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SEND = 2'b10
    } ardr_tx_state_type;

    localparam int SHW = ardr_pkg::DATA_WIDTH + 1;

    ardr_tx_state_type state_q;
    logic [15:0] div_q;
    logic [4:0] left_q;
    logic [SHW-1:0] shreg_q;
    logic line_q;

    wire [3:0] payload = (frame_bits < ardr_pkg::PAYLOAD_MIN) ? ardr_pkg::PAYLOAD_MIN :
                         (frame_bits > ardr_pkg::PAYLOAD_MAX) ? ardr_pkg::PAYLOAD_MAX : frame_bits;
    wire [4:0] total_bits = 5'(payload) + 5'(STOP_BITS) + 5'h01;
    // Divider keeps the bit period exact to one clock: its share of the mismatch
    wire bit_done = div_q == 16'(CLKS_PER_BIT - 1);
    wire [SHW-1:0] mask = (SHW)'((1 << payload) - 1);
    wire take = in_valid && in_ready;

    assign in_ready = state_q == ST_IDLE;
    assign link.serial_line = line_q;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
            div_q <= 16'h0000;
            left_q <= 5'h00;
            shreg_q <= '1;
            line_q <= ardr_pkg::LINE_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (take) begin
                        state_q <= ST_SEND;
                        shreg_q <= {(in_data & mask[SHW-2:0]) | ~mask[SHW-2:0], 1'b1};
                        line_q <= 1'b0;
                        left_q <= total_bits - 5'h01;
                        div_q <= 16'h0000;
                    end
                end
                ST_SEND: begin
                    div_q <= bit_done ? 16'h0000 : div_q + 16'h0001;
                    if (bit_done) begin
                        if (left_q == 5'h00) begin
                            state_q <= ST_IDLE;
                            line_q <= ardr_pkg::LINE_IDLE;
                        end else begin
                            shreg_q <= {1'b1, shreg_q[SHW-1:1]};
                            line_q <= shreg_q[1];
                            left_q <= left_q - 5'h01;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule : ardr_tx_end
`default_nettype wire

// [verification/ardr_link_monitor.sv]
// Concurrent checks on the serial link and the handshakes of both ends
`timescale 1ns/1ns
`default_nettype none
module ardr_link_monitor (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic serial_line,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire logic out_valid,
    input wire logic out_ready
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    chk_line_idle_reset: assert property ($fell(reset) |-> serial_line)
        else $error("line not idle after reset");
    chk_ends_empty: assert property ($fell(reset) |-> in_ready && !out_valid)
        else $error("ends not empty after reset");
    chk_start_on_take: assert property (in_valid && in_ready |=> !serial_line && !in_ready)
        else $error("start bit not launched");
    chk_start_bit_held: assert property ($fell(serial_line) |-> !serial_line [*8])
        else $error("start bit too short");
    chk_bit_stable: assert property ($changed(serial_line) |=> $stable(serial_line) [*8])
        else $error("bit period too short");
    chk_frame_delivered: assert property (in_valid && in_ready |-> ##[1:400] out_valid)
        else $error("frame not delivered");
    chk_no_early_word: assert property (in_valid && in_ready && !out_valid |=> !out_valid [*8])
        else $error("word before frame end");
    chk_word_holds: assert property (out_valid && !out_ready |=> out_valid)
        else $error("word lost before pop");
endmodule : ardr_link_monitor
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench joining both ends, plus a second receiver fed by a line driver
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic tick = 1'b1;
    logic [1:0] mode = 2'h0;
    logic [3:0] dbits = 4'h8;
    logic tx_valid = 1'b0;
    logic tx_ready;
    logic [9:0] tx_data = 10'h000;
    logic rx_valid, rx_err, b_valid, b_err;
    logic rx_ready = 1'b0;
    logic [9:0] rx_data, b_data, d, e;
    logic line_b = 1'b1;
    int miscompares = 0;
    int n_compared = 0;
    ardr_link_if link_a();
    ardr_link_if link_b();
    assign link_b.serial_line = line_b;
    ardr_tx_end #(.CLKS_PER_BIT(16), .STOP_BITS(1)) ardr_tx_end_inst (.ref_clk(ref_clk), .reset(reset),
        .in_valid(tx_valid), .in_ready(tx_ready), .in_data(tx_data), .frame_bits(dbits), .link(link_a.tx_end));
    ardr_rx_end ardr_rx_end_inst (.ref_clk(ref_clk), .reset(reset), .sample_tick(tick), .rx_sampling_mode(mode),
        .frame_bits(dbits), .link(link_a.rx_end), .out_valid(rx_valid), .out_ready(rx_ready), .out_data(rx_data),
        .out_frame_err(rx_err));
    ardr_rx_end ardr_rx_end_inst_b (.ref_clk(ref_clk), .reset(reset), .sample_tick(tick),
        .rx_sampling_mode(mode), .frame_bits(dbits), .link(link_b.rx_end), .out_valid(b_valid),
        .out_ready(rx_ready), .out_data(b_data), .out_frame_err(b_err));
    ardr_link_monitor ardr_link_monitor_inst (.ref_clk(ref_clk), .reset(reset), .serial_line(link_a.serial_line),
        .in_valid(tx_valid), .in_ready(tx_ready), .out_valid(rx_valid), .out_ready(rx_ready));
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    // Eight ticks per 16-clock bit in double speed
    always @(negedge ref_clk) begin
        tick <= (mode == ardr_pkg::MODE_DOUBLE) ? ~tick : 1'b1;
    end
    function automatic logic [9:0] masked(input logic [9:0] v, input logic [3:0] n);
        return v & ((10'h001 << n) - 10'h001);
    endfunction : masked
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch word expected %h seen %h", exp, seen);
        end
    endtask : check
    task automatic close_out();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out
    task automatic idle_tx();
        for (int n = 0; n < 400 && tx_ready !== 1'b1; n++) begin
            @(negedge ref_clk);
        end
    endtask : idle_tx
    task automatic send(input logic [9:0] v);
        idle_tx();
        tx_valid = 1'b1;
        tx_data = v;
        @(negedge ref_clk);
        tx_valid = 1'b0;
    endtask : send
    task automatic pop(input logic b, input logic [9:0] v, input logic err);
        for (int n = 0; n < 600 && (b ? b_valid : rx_valid) !== 1'b1; n++) begin
            @(negedge ref_clk);
        end
        check({10'h000, (b ? b_valid : rx_valid)}, 11'h001);
        check(b ? {b_err, b_data} : {rx_err, rx_data}, {err, v});
        rx_ready = 1'b1;
        @(negedge ref_clk);
        rx_ready = 1'b0;
        @(negedge ref_clk);
    endtask : pop
    task automatic drive(input logic lvl, input int n);
        line_b = lvl;
        repeat (n) @(negedge ref_clk);
    endtask : drive
    task automatic frame_b(input logic [7:0] x, input logic stop, input int slen);
        drive(1'b0, 16);
        for (int k = 0; k < 8; k++) begin
            drive(x[k], 16);
        end
        drive(stop, slen);
    endtask : frame_b
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        close_out();
    end
    initial begin
        repeat (2) @(negedge ref_clk);
        reset = 1'b0;
        void'($urandom(32'h4D6D));
        for (int m = 0; m < 2; m++) begin
            mode = m[1:0];
            for (int i = 0; i < 6; i++) begin
                dbits = 4'h5 + i[3:0];
                d = 10'($urandom);
                e = 10'($urandom);
                send(d);
                send(e);
                pop(1'b0, masked(d, dbits), 1'b0);
                pop(1'b0, masked(e, dbits), 1'b0);
            end
        end
        mode = ardr_pkg::MODE_NORMAL;
        dbits = 4'h5;
        for (int i = 0; i < 18; i++) begin
            send(10'(i));
        end
        idle_tx();
        for (int i = 0; i < 17; i++) begin
            pop(1'b0, 10'(i), 1'b0);
        end
        check({10'h000, rx_valid}, 11'h000);
        dbits = 4'h8;
        drive(1'b0, 7);
        drive(1'b1, 300);
        check({10'h000, b_valid}, 11'h000);
        drive(1'b0, 9);
        drive(1'b1, 200);
        pop(1'b1, 10'h0FF, 1'b0);
        frame_b(8'hA5, 1'b0, 16);
        drive(1'b1, 16);
        frame_b(8'h3C, 1'b1, 10);
        frame_b(8'h96, 1'b1, 16);
        pop(1'b1, 10'h0A5, 1'b1);
        pop(1'b1, 10'h03C, 1'b0);
        pop(1'b1, 10'h096, 1'b0);
        // Double speed: next start begins on the first sample after the stop vote
        mode = ardr_pkg::MODE_DOUBLE;
        drive(1'b1, 16);
        frame_b(8'h5A, 1'b1, 12);
        frame_b(8'hC3, 1'b1, 16);
        pop(1'b1, 10'h05A, 1'b0);
        pop(1'b1, 10'h0C3, 1'b0);
        close_out();
    end
endmodule : tb
`default_nettype wire
